// [src/canopen_status_diagnostics.sv]
`timescale 1ns/1ns
module canopen_status_diagnostics
   import can_diag_pkg::*;
#(
   parameter int SLOT_CYCLES = LED_SLOT_CYC,
   parameter int CHANNELS    = 4
) (
   input  wire logic                 sys_clk,
   input  wire logic                 reset,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   input  wire logic                 ctrl_off,
   input  wire logic                 ctrl_bus_off,
   input  wire logic                 ctrl_error,
   input  wire logic                 ctrl_overrun,
   input  wire logic                 ctrl_rx_overrun,
   input  wire logic                 guard_event,
   input  wire logic                 hbeat_event,
   input  wire logic                 nmt_error,
   input  wire nmt_state_t           nmt_state_in,
   input  wire logic                 rx_pdo,
   input  wire logic                 tx_pdo,
   input  wire logic [1:0]           pdo_set,
   input  wire logic [3:0]           pdo_bytes,
   input  wire logic                 par_wr,
   input  wire logic [1:0]           par_chan,
   input  wire logic                 par_is_ref,
   input  wire logic [15:0]          par_data,
   input  wire logic [CHANNELS-1:0]  comm_warning,
   output logic                      run_led,
   output logic                      err_led,
   output logic                      nmt_reinit,
   output logic                      comm_interrupt,
   output logic [15:0]               active_cmd,
   output logic [15:0]               active_ref,
   output logic                      irq
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [5:0]          ctrl;
   logic [7:0]          err_code;
   logic [15:0]         rx_count;
   logic [15:0]         tx_count;
   logic [IRQ_BITS-1:0] irq_stat;
   logic [IRQ_BITS-1:0] irq_mask;
   logic [IRQ_BITS-1:0] rd_clear;
   logic [IRQ_BITS-1:0] events;
   logic [CHANNELS-1:0] written;
   logic [CHANNELS-1:0] monitored;
   logic [15:0]         cmd_word [CHANNELS];
   logic [15:0]         ref_word [CHANNELS];
   logic [2:0]          pdo_words [3];
   logic                bus_off_q;
   logic                guard_seen;
   logic [31:0]         slot_cnt;
   logic                slot_tick;
   logic [2:0]          sflash_ph;
   logic [2:0]          dflash_ph;
   logic                blink;
   logic                setup;
   logic                access_done;
   logic [1:0]          act_chan;
   logic [1:0]          sw_chan;
   logic [1:0]          ovr_sel;
   logic [31:0]         next_rdata;
   logic                next_err;

   // words carried by a pdo of the given byte length
   function automatic logic [2:0] words_of(input logic [3:0] bytes);
      logic [4:0] sum;
      sum = {1'b0, bytes} + 5'h01;
      return sum[3:1];
   endfunction

   assign act_chan    = ctrl[ACT_CHAN_LSB +: 2];
   assign sw_chan     = ctrl[SW_CHAN_LSB +: 2];
   assign ovr_sel     = ctrl[OVR_SEL_LSB +: 2];
   assign setup       = psel & ~penable;
   assign access_done = psel & penable & pready;

   // ----------------------------------------------------------------
   // apb slave, no wait state; read data is registered from the setup cycle
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      unique case (paddr)
         CTRL_OFS:      next_rdata = {26'h0, ctrl};
         NMT_OFS:       next_rdata = {30'h0, nmt_state_in};
         ERR_CODE_OFS:  next_rdata = {24'h0, err_code};
         PDO_COUNT_OFS: next_rdata = {tx_count, rx_count};
         IRQ_STAT_OFS:  next_rdata = {25'h0, irq_stat};
         IRQ_MASK_OFS:  next_rdata = {25'h0, irq_mask};
         CHAN_STAT_OFS: next_rdata = {24'h0, 4'(monitored), 4'(written)};
         PDO_WORDS_OFS: next_rdata = {23'h0, pdo_words[2], pdo_words[1],
                                      pdo_words[0]};
         ACT_VAL_OFS:   next_rdata = {active_ref, active_cmd};
         default:       next_err   = 1'b1;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup & next_err;
         if (setup && !pwrite) begin
            prdata <= next_rdata;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctrl     <= CTRL_RESET;
         irq_mask <= IRQ_MASK_RESET[IRQ_BITS-1:0];
      end else if (access_done && pwrite) begin
         if (paddr == CTRL_OFS) begin
            ctrl <= pwdata[5:0];
         end
         if (paddr == IRQ_MASK_OFS) begin
            irq_mask <= pwdata[IRQ_BITS-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupts: sticky, cleared by a status read, set wins
   // ----------------------------------------------------------------
   always_comb begin
      events = '0;
      events[IRQ_BUS_OFF]  = ctrl_bus_off & ~bus_off_q;
      events[IRQ_OVERRUN]  = ctrl_overrun;
      events[IRQ_GUARD]    = guard_event;
      events[IRQ_HBEAT]    = hbeat_event;
      events[IRQ_RX_OVR]   = ctrl_rx_overrun;
      events[IRQ_NMT_ERR]  = nmt_error;
      events[IRQ_COMM_INT] = |(comm_warning & monitored);
   end

   assign rd_clear = (access_done && !pwrite && paddr == IRQ_STAT_OFS) ?
                     prdata[IRQ_BITS-1:0] : '0;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_stat  <= '0;
         irq       <= 1'b0;
         bus_off_q <= 1'b0;
      end else begin
         irq_stat  <= (irq_stat & ~rd_clear) | events;
         irq       <= |(((irq_stat & ~rd_clear) | events) & irq_mask);
         bus_off_q <= ctrl_bus_off;
      end
   end

   // ----------------------------------------------------------------
   // last error code
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         err_code   <= ERR_NONE;
         nmt_reinit <= 1'b0;
      end else begin
         nmt_reinit <= guard_event | hbeat_event;
         // priority: bus-off and controller overrun first, then guarding, heartbeat, rx overrun, nmt error
         if (events[IRQ_BUS_OFF] || ctrl_overrun) begin
            err_code <= ERR_BUS_OFF;
         end else if (guard_event) begin
            err_code <= ERR_GUARD;
         end else if (hbeat_event) begin
            err_code <= ERR_HBEAT;
         end else if (ctrl_rx_overrun) begin
            unique case (ovr_sel)
               2'h0: err_code <= ERR_RX_OVR;
               2'h1: err_code <= ERR_OVR_32;
               2'h2: err_code <= ERR_OVR_64;
               2'h3: err_code <= ERR_OVR_128;
            endcase
         end else if (nmt_error) begin
            err_code <= ERR_NMT;
         end else if (access_done && pwrite && paddr == ERR_CODE_OFS) begin
            err_code <= ERR_NONE;
         end
      end
   end

   // ----------------------------------------------------------------
   // pdo counters and word display
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rx_count <= 16'h0000;
         tx_count <= 16'h0000;
      end else begin
         // natural 16 bit overflow gives the wrap after 65535
         if (rx_pdo) begin
            rx_count <= rx_count + 16'h0001;
         end
         if (tx_pdo) begin
            tx_count <= tx_count + 16'h0001;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         for (int i = 0; i < 3; i++) begin
            pdo_words[i] <= 3'h0;
         end
      end else if ((rx_pdo || tx_pdo) && pdo_set != 2'h3) begin
         pdo_words[pdo_set] <= words_of(pdo_bytes);
      end
   end

   // ----------------------------------------------------------------
   // per channel command and reference, monitoring
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         written <= '0;
         for (int i = 0; i < CHANNELS; i++) begin
            cmd_word[i] <= 16'h0000;
            ref_word[i] <= 16'h0000;
         end
      end else if (par_wr) begin
         written[par_chan] <= 1'b1;
         if (par_is_ref) begin
            ref_word[par_chan] <= par_data;
         end else begin
            cmd_word[par_chan] <= par_data;
         end
      end
   end

   always_comb begin
      monitored = '0;
      for (int i = 0; i < CHANNELS; i++) begin
         monitored[i] = written[i] &&
                        (act_chan == 2'(i) || sw_chan == 2'(i));
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         active_cmd     <= 16'h0000;
         active_ref     <= 16'h0000;
         comm_interrupt <= 1'b0;
      end else begin
         active_cmd     <= cmd_word[act_chan];
         active_ref     <= ref_word[act_chan];
         comm_interrupt <= |(comm_warning & monitored);
      end
   end

   // ----------------------------------------------------------------
   // indicator timing
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         slot_cnt  <= 32'h0000_0000;
         slot_tick <= 1'b0;
      end else begin
         slot_tick <= (slot_cnt == 32'(SLOT_CYCLES - 1));
         if (slot_cnt == 32'(SLOT_CYCLES - 1)) begin
            slot_cnt <= 32'h0000_0000;
         end else begin
            slot_cnt <= slot_cnt + 32'h0000_0001;
         end
      end
   end

   // single flash: on 1 slot of 6; double: on slots 0 and 2 of 8
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sflash_ph <= 3'h0;
         dflash_ph <= 3'h0;
         blink     <= 1'b0;
      end else if (slot_tick) begin
         sflash_ph <= (sflash_ph == SFLASH_SLOTS - 3'h1) ? 3'h0 :
                      sflash_ph + 3'h1;
         dflash_ph <= dflash_ph + 3'h1;
         blink     <= ~blink;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         guard_seen <= 1'b0;
      end else if (guard_event || hbeat_event) begin
         guard_seen <= 1'b1;
      end else if (access_done && pwrite && paddr == ERR_CODE_OFS) begin
         guard_seen <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         run_led <= 1'b0;
         err_led <= 1'b0;
      end else begin
         if (ctrl_off) begin
            run_led <= 1'b0;
         end else begin
            unique case (nmt_state_in)
               NMT_STOPPED:     run_led <= (sflash_ph == 3'h0);
               NMT_PREOP:       run_led <= blink;
               NMT_OPERATIONAL: run_led <= 1'b1;
               NMT_BOOT:        run_led <= 1'b0;
            endcase
         end
         if (ctrl_bus_off) begin
            err_led <= 1'b1;
         end else if (guard_seen) begin
            err_led <= (dflash_ph == 3'h0 || dflash_ph == 3'h2);
         end else if (ctrl_error) begin
            err_led <= (sflash_ph == 3'h0);
         end else begin
            err_led <= 1'b0;
         end
      end
   end

endmodule // canopen_status_diagnostics

// [src/can_diag_pkg.sv]
package can_diag_pkg;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS      = 8'h00;
   localparam logic [7:0] NMT_OFS       = 8'h04;
   localparam logic [7:0] ERR_CODE_OFS  = 8'h08;
   localparam logic [7:0] PDO_COUNT_OFS = 8'h0c;
   localparam logic [7:0] IRQ_STAT_OFS  = 8'h10;
   localparam logic [7:0] IRQ_MASK_OFS  = 8'h14;
   localparam logic [7:0] CHAN_STAT_OFS = 8'h18;
   localparam logic [7:0] PDO_WORDS_OFS = 8'h1c;
   localparam logic [7:0] ACT_VAL_OFS   = 8'h20;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int ACT_CHAN_LSB = 0;
   localparam int SW_CHAN_LSB  = 2;
   localparam int OVR_SEL_LSB  = 4;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

   // irq status bit positions
   localparam int IRQ_BUS_OFF  = 0;
   localparam int IRQ_OVERRUN  = 1;
   localparam int IRQ_GUARD    = 2;
   localparam int IRQ_HBEAT    = 3;
   localparam int IRQ_RX_OVR   = 4;
   localparam int IRQ_NMT_ERR  = 5;
   localparam int IRQ_COMM_INT = 6;
   localparam int IRQ_BITS     = 7;

   // ----------------------------------------------------------------
   // last error codes
   // ----------------------------------------------------------------
   localparam logic [7:0] ERR_NONE    = 8'h00;
   localparam logic [7:0] ERR_BUS_OFF = 8'h01;
   localparam logic [7:0] ERR_GUARD   = 8'h02;
   localparam logic [7:0] ERR_RX_OVR  = 8'h03;
   localparam logic [7:0] ERR_HBEAT   = 8'h04;
   localparam logic [7:0] ERR_NMT     = 8'h05;
   localparam logic [7:0] ERR_OVR_32  = 8'h20;
   localparam logic [7:0] ERR_OVR_64  = 8'h40;
   localparam logic [7:0] ERR_OVR_128 = 8'h80;

   // ----------------------------------------------------------------
   // indicator timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ        = 10_000_000;
   localparam int LED_SLOT_MS   = 200;
   localparam int LED_SLOT_CYC  = CLK_HZ / 1000 * LED_SLOT_MS;
   localparam logic [2:0] SFLASH_SLOTS = 3'h6;
   localparam logic [2:0] DFLASH_SLOTS = 3'h7;

   typedef enum logic [1:0] {
      NMT_BOOT,
      NMT_STOPPED,
      NMT_OPERATIONAL,
      NMT_PREOP
   } nmt_state_t;
endpackage

// [verification/can_diag_checker.sv]
`timescale 1ns/1ns
module can_diag_checker
   import can_diag_pkg::*;
#(
   parameter int SLOT_CYCLES = LED_SLOT_CYC,
   parameter int CHANNELS    = 4
) (
   input wire logic                sys_clk,
   input wire logic                reset,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire logic                ctrl_off,
   input wire logic                ctrl_bus_off,
   input wire logic                guard_event,
   input wire logic                hbeat_event,
   input wire nmt_state_t          nmt_state_in,
   input wire logic [CHANNELS-1:0] comm_warning,
   input wire logic                run_led,
   input wire logic                err_led,
   input wire logic                nmt_reinit,
   input wire logic                comm_interrupt
);
   // ----------------------------------------------------------------
   // port relations
   // ----------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // reset is sampled in antecedents: the release edge still shows reset
   sequence setup_s;
      !reset && psel && !penable;
   endsequence
   sequence answer_s;
      pready ##1 !pready;
   endsequence
   AST_APB_ANSWER: assert property (setup_s |=> answer_s)
      else $error("apb answer not one cycle");
   AST_APB_CAUSE: assert property (pready |-> $past(psel && !penable))
      else $error("pready without setup");
   AST_SLVERR: assert property (pslverr |-> pready)
      else $error("pslverr outside access");
   AST_RUN_DARK: assert property (ctrl_off |=> !run_led)
      else $error("run led lit while off");
   AST_RUN_STEADY: assert property (
      !reset && !ctrl_off && nmt_state_in == NMT_OPERATIONAL |=> run_led)
      else $error("run led not steady");
   AST_ERR_BUSOFF: assert property (
      !reset && ctrl_bus_off |=> err_led)
      else $error("err led dark in bus-off");
   AST_REINIT: assert property (
      !reset && (guard_event || hbeat_event) |=> nmt_reinit)
      else $error("no reinit request");
   AST_REINIT_CAUSE: assert property (
      nmt_reinit |-> $past(guard_event || hbeat_event))
      else $error("reinit without event");
   AST_COMM_CAUSE: assert property (
      comm_interrupt |-> $past(|comm_warning))
      else $error("interruption without warning");
endmodule // can_diag_checker

bind canopen_status_diagnostics can_diag_checker #(
   .SLOT_CYCLES(SLOT_CYCLES), .CHANNELS(CHANNELS)
) i_chk (
   .sys_clk, .reset, .psel, .penable, .pready, .pslverr, .ctrl_off,
   .ctrl_bus_off, .guard_event, .hbeat_event, .nmt_state_in,
   .comm_warning, .run_led, .err_led, .nmt_reinit, .comm_interrupt
);

// [verification/can_node_model.sv]
`timescale 1ns/1ns
module can_node_model
   import can_diag_pkg::*;
(
   input  wire logic  sys_clk,
   output logic       ctrl_off,
   output logic       ctrl_bus_off,
   output logic       ctrl_error,
   output logic       ctrl_overrun,
   output logic       ctrl_rx_overrun,
   output logic       guard_event,
   output logic       hbeat_event,
   output logic       nmt_error,
   output nmt_state_t nmt_state_in,
   output logic       rx_pdo,
   output logic       tx_pdo,
   output logic [1:0] pdo_set,
   output logic [3:0] pdo_bytes
);
   // ----------------------------------------------------------------
   // bus side stimulus
   // ----------------------------------------------------------------
   logic [4:0] pls;
   assign {nmt_error, ctrl_rx_overrun, hbeat_event, guard_event,
           ctrl_overrun} = pls;
   initial begin
      pls = '0;
      {ctrl_off, ctrl_bus_off, ctrl_error, rx_pdo, tx_pdo} = '0;
      {pdo_set, pdo_bytes} = '0;
      nmt_state_in = NMT_BOOT;
   end
   task lvl(input logic o, bo, er, input nmt_state_t st);
      @(posedge sys_clk);
      ctrl_off <= o;
      ctrl_bus_off <= bo;
      ctrl_error <= er;
      nmt_state_in <= st;
   endtask
   task pulse(input logic [4:0] v);
      @(posedge sys_clk);
      pls <= v;
      @(posedge sys_clk);
      pls <= '0;
   endtask
   // idle qualifiers flip so stale values never look valid
   task burst(input logic rx, input int n, input logic [1:0] s,
              input logic [3:0] b);
      @(posedge sys_clk);
      rx_pdo <= rx;
      tx_pdo <= !rx;
      pdo_set <= s;
      pdo_bytes <= b;
      repeat (n) @(posedge sys_clk);
      rx_pdo <= 0;
      tx_pdo <= 0;
      pdo_set <= ~s;
      pdo_bytes <= ~b;
   endtask
endmodule // can_node_model

// [verification/canopen_status_diagnostics_tb_top.sv]
`timescale 1ns/1ns
module canopen_status_diagnostics_tb_top;
   import can_diag_pkg::*;
   localparam int SLOT = 4;
   logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
   logic par_wr = 0, par_is_ref = 0, e;
   logic [1:0]  par_chan = 0;
   logic [3:0]  comm_warning = 0;
   logic [7:0]  paddr = 0;
   logic [15:0] par_data = 0, rx_n = 0, tx_n = 0, d [3];
   logic [31:0] pwdata = 0, prdata, rd, r;
   logic [2:0]  wd [3] = '{0, 0, 0};
   logic pready, pslverr, run_led, err_led, nmt_reinit, comm_interrupt;
   logic irq, ctrl_off, ctrl_bus_off, ctrl_error, ctrl_overrun;
   logic ctrl_rx_overrun, guard_event, hbeat_event, nmt_error;
   logic rx_pdo, tx_pdo;
   logic [1:0] pdo_set;
   logic [3:0] pdo_bytes;
   logic [15:0] active_cmd, active_ref;
   nmt_state_t nmt_state_in;
   int error_cnt = 0, checked = 0, seed = 12, s, b;

   always #50 sys_clk = ~sys_clk;

   canopen_status_diagnostics #(.SLOT_CYCLES(SLOT)) i_dut (
      .sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .ctrl_off, .ctrl_bus_off, .ctrl_error,
      .ctrl_overrun, .ctrl_rx_overrun, .guard_event, .hbeat_event,
      .nmt_error, .nmt_state_in, .rx_pdo, .tx_pdo, .pdo_set, .pdo_bytes,
      .par_wr, .par_chan, .par_is_ref, .par_data, .comm_warning,
      .run_led, .err_led, .nmt_reinit, .comm_interrupt, .active_cmd,
      .active_ref, .irq);
   can_node_model p (
      .sys_clk, .ctrl_off, .ctrl_bus_off, .ctrl_error, .ctrl_overrun,
      .ctrl_rx_overrun, .guard_event, .hbeat_event, .nmt_error,
      .nmt_state_in, .rx_pdo, .tx_pdo, .pdo_set, .pdo_bytes);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task chk(input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] dt);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dt;
      @(posedge sys_clk);
      penable <= 1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      chk(n, 1); // slave answers in the first access cycle, no wait state
   endtask
   // duty counted over whole pattern periods, so phase does not matter
   task automatic led(input bit run, input int slots, input int ex);
      int c;
      c = 0;
      // first edge still shows the led of the old inputs
      @(posedge sys_clk);
      repeat (slots * SLOT) begin
         @(posedge sys_clk);
         c += run ? run_led : err_led;
      end
      chk(c, ex * SLOT);
   endtask
   task pw(input logic [1:0] c, input logic f, input logic [15:0] v);
      @(posedge sys_clk);
      par_wr <= 1;
      par_chan <= c;
      par_is_ref <= f;
      par_data <= v;
      @(posedge sys_clk);
      par_wr <= 0;
      par_data <= ~v;
   endtask
   task warn(input logic [3:0] w, input logic ex);
      @(posedge sys_clk);
      comm_warning <= w;
      @(posedge sys_clk);
      comm_warning <= 0;
      @(posedge sys_clk);
      chk(comm_interrupt, ex);
   endtask
   function automatic logic [7:0] exp_code(input int k);
      case (k)
         0, 1: return ERR_BUS_OFF;
         2: return ERR_GUARD;
         3: return ERR_HBEAT;
         4: return ERR_RX_OVR;
         5: return ERR_OVR_32;
         6: return ERR_OVR_64;
         7: return ERR_OVR_128;
         default: return ERR_NMT;
      endcase
   endfunction
   task give_verdict;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (95000) @(posedge sys_clk);
      error_cnt++;
      give_verdict;
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      reset <= 0;
      foreach (d[i]) begin
         apb(0, 8'(4 * i + 4), 0);
         if (i == 1) chk(rd, 0);
      end
      apb(1, 8'h24, 32'hffff_ffff);
      chk(e, 1);
      apb(0, 8'h24, 0);
      chk(e, 1);
      chk(rd, 0);
      for (s = 0; s < 4; s++) begin
         p.lvl(0, 0, 0, nmt_state_t'(s));
         repeat (3) @(posedge sys_clk);
         apb(0, NMT_OFS, 0);
         chk(rd, s);
         if (s == 1) led(1, 12, 2);
         if (s > 1) led(1, 4 * (s - 1), 4);
      end
      p.lvl(1, 0, 0, NMT_OPERATIONAL);
      led(1, 4, 0);
      p.lvl(0, 0, 0, NMT_OPERATIONAL);
      for (int k = 0; k < 9; k++) begin
         apb(1, IRQ_MASK_OFS, k % 2 ? 32'h7f : 32'h0);
         apb(1, CTRL_OFS, k > 3 && k < 8 ? (k - 4) << OVR_SEL_LSB : 0);
         if (k == 0) begin
            p.lvl(0, 1, 0, NMT_OPERATIONAL);
            led(0, 2, 2);
            p.lvl(0, 0, 0, NMT_OPERATIONAL);
         end else p.pulse(5'h1 << (k < 4 ? k - 1 : k < 8 ? 3 : 4));
         repeat (3) @(posedge sys_clk);
         chk(irq, k % 2);
         apb(0, ERR_CODE_OFS, 0);
         chk(rd, exp_code(k));
         if (k == 2 || k == 3) led(0, 16, 4);
         apb(0, IRQ_STAT_OFS, 0);
         chk(rd, 32'h1 << (k < 4 ? k : k < 8 ? 4 : 5));
         repeat (2) @(posedge sys_clk);
         chk(irq, 0);
         apb(1, ERR_CODE_OFS, 0);
         apb(0, ERR_CODE_OFS, 0);
         chk(rd, 0);
      end
      p.lvl(0, 0, 1, NMT_OPERATIONAL);
      led(0, 12, 2);
      p.lvl(0, 0, 0, NMT_OPERATIONAL);
      repeat (2) @(posedge sys_clk);
      led(0, 4, 0);
      repeat (30) begin
         r = $random(seed);
         s = r[7:0] % 3;
         b = r[15:8] % 9;
         p.burst(r[16], 1, s[1:0], b[3:0]);
         if (r[16]) rx_n++;
         else tx_n++;
         wd[s] = 3'((b + 1) / 2);
         repeat (r[18:17]) @(posedge sys_clk);
      end
      // a full lap of 65536 brings the receive count back unchanged
      p.burst(1, 65536, 2'd0, 4'd3);
      wd[0] = 2;
      p.burst(0, 3, 2'd1, 4'd8);
      tx_n += 3;
      wd[1] = 4;
      repeat (3) @(posedge sys_clk);
      apb(0, PDO_COUNT_OFS, 0);
      chk(rd, {tx_n, rx_n});
      apb(0, PDO_WORDS_OFS, 0);
      chk(rd, {23'h0, wd[2], wd[1], wd[0]});
      foreach (d[i]) d[i] = 16'($random(seed));
      apb(1, CTRL_OFS, 32'h5);
      pw(1, 0, d[0]);
      pw(1, 1, d[1]);
      pw(2, 0, d[2]);
      repeat (3) @(posedge sys_clk);
      chk({active_ref, active_cmd}, {d[1], d[0]});
      apb(0, ACT_VAL_OFS, 0);
      chk(rd, {d[1], d[0]});
      apb(0, CHAN_STAT_OFS, 0);
      chk(rd, 32'h26);
      warn(4'b0100, 0);
      warn(4'b0010, 1);
      warn(4'b1000, 0);
      apb(1, CTRL_OFS, 32'h9);
      warn(4'b0100, 1);
      // mid-run reset must clear counters and sticky status
      reset <= 1;
      repeat (3) @(posedge sys_clk);
      reset <= 0;
      apb(0, PDO_COUNT_OFS, 0);
      chk(rd, 0);
      apb(0, IRQ_STAT_OFS, 0);
      chk(rd, 0);
      give_verdict;
   end
endmodule // canopen_status_diagnostics_tb_top
